// ### logic/bank_close_regs.svh
// Purpose: Register map, field positions and reset values of the bank close block
// Assumes: APB, 32-bit data, one register per aligned word
// Notes: Definitions only
`ifndef BANK_CLOSE_REGS_SVH
`define BANK_CLOSE_REGS_SVH

// Register byte offsets
`define BC_CFG_OFF 8'h00
`define BC_TIM_OFF 8'h04
`define BC_STAT_OFF 8'h08

// CFG fields
`define BC_CFG_NRTP 7:0
`define BC_CFG_NWR 15:8
`define BC_CFG_WL 23:16
`define BC_CFG_BL32 24

// TIM fields
`define BC_TIM_TRAS 7:0
`define BC_TIM_TRP 15:8
`define BC_TIM_TRPAB 23:16

// STAT fields
`define BC_STAT_OPEN 7:0
`define BC_STAT_BUSY 15:8
`define BC_STAT_APPEND 23:16

// Reset values, in clock cycles
`define BC_RST_NRTP 8'h08
`define BC_RST_NWR 8'h08
`define BC_RST_WL 8'h04
`define BC_RST_TRAS 8'h28
`define BC_RST_TRP 8'h12
`define BC_RST_TRPAB 8'h15

// Command field positions
`define BC_CA_FLAG 5
`define BC_CA_BANK 2:0

// Burst timing terms
`define BC_HALF_BL16 10'h008
`define BC_HALF_BL32 10'h010
`define BC_RD32_EXTRA 10'h008
`define BC_WR_EXTRA 10'h001
`define BC_ZERO10 10'h000

`endif

// ### logic/bank_close_pkg.sv
// Purpose: Types shared by the bank close block
// Assumes: Eight banks per channel
// Notes: Constants live in bank_close_regs.svh
`default_nettype none
package bank_close_pkg;

    typedef enum logic [2:0] {OP_NONE, OP_ACT, OP_RD, OP_WR, OP_MWR, OP_PRE} cmd_op_t;

    typedef struct packed {
        cmd_op_t op;
        logic [5:0] ca1;
        logic [5:0] ca2;
    } cmd_in_t;

    typedef struct packed {
        logic open;
        logic ap_pend;
        logic [9:0] ap_cnt;
        logic [7:0] ras_cnt;
        logic [7:0] rp_cnt;
    } bank_t;

    typedef struct packed {
        logic [7:0] nrtp;
        logic [7:0] nwr;
        logic [7:0] wl;
        logic bl32;
        logic [7:0] tras;
        logic [7:0] trp;
        logic [7:0] trpab;
    } cfg_t;

    typedef struct packed {
        cmd_in_t sync1;
        cmd_in_t sync2;
        cfg_t cfg;
        bank_t [7:0] bank;
        logic [7:0] close;
        logic [31:0] prdata;
    } state_t;

endpackage
`default_nettype wire

// ### logic/bank_precharge_timing.sv
// Purpose: Bank close timing of one DRAM channel: explicit and automatic close
// Assumes: Command pins change in step with pclk; they pass two flops first
// Notes: Counts are in pclk cycles, loaded from the CFG and TIM registers
`timescale 1ns/1ns
`default_nettype none
`include "bank_close_regs.svh"

module bank_precharge_timing (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command pins from the memory controller
    input wire bank_close_pkg::cmd_in_t cmd_in,
    // Bank state
    output logic [7:0] bank_open,
    output logic [7:0] bank_close_start
);
    import bank_close_pkg::*;

    state_t q;
    state_t d;
    logic [7:0] busy;
    logic [7:0] ap_pend;
    logic wr_acc;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Status views

    always_comb begin
        for (int b = 0; b < 8; b++) begin
            // Recovery window still running, so an activate is not yet legal
            busy[b] = (q.bank[b].rp_cnt != 8'h00);
            ap_pend[b] = q.bank[b].ap_pend;
            bank_open[b] = q.bank[b].open;
        end
    end

    assign mapped = (paddr == `BC_CFG_OFF) || (paddr == `BC_TIM_OFF) || (paddr == `BC_STAT_OFF);
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = q.prdata;
    assign bank_close_start = q.close;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        cmd_in_t c;
        logic hit;
        logic all_flag;
        logic [9:0] rd_delay;
        logic [9:0] wr_delay;
        c = q.sync2;
        hit = 1'b0;
        d = q;
        d.sync1 = cmd_in;
        d.sync2 = q.sync1;
        d.close = 8'h00;
        all_flag = c.ca1[`BC_CA_FLAG];
        // Read delay: tRTP, plus eight cycles when bursts are 32 long
        rd_delay = {2'b00, q.cfg.nrtp} + (q.cfg.bl32 ? `BC_RD32_EXTRA : `BC_ZERO10);
        // Burst ends at WL+BL/2; BL is 16 or 32, so that is a prefetch boundary
        wr_delay = {2'b00, q.cfg.wl} + (q.cfg.bl32 ? `BC_HALF_BL32 : `BC_HALF_BL16)
            + `BC_WR_EXTRA + {2'b00, q.cfg.nwr};

        for (int b = 0; b < 8; b++) begin
            hit = (c.ca2[`BC_CA_BANK] == 3'(b));
            if (q.bank[b].ras_cnt != 8'h00) begin
                d.bank[b].ras_cnt = q.bank[b].ras_cnt - 8'h01;
            end
            if (q.bank[b].rp_cnt != 8'h00) begin
                d.bank[b].rp_cnt = q.bank[b].rp_cnt - 8'h01;
            end
            if (q.bank[b].ap_pend && q.bank[b].ap_cnt != `BC_ZERO10) begin
                d.bank[b].ap_cnt = q.bank[b].ap_cnt - 10'h001;
            end
            // RAS lockout: the automatic close waits for tRAS as well
            if (q.bank[b].ap_pend && q.bank[b].ap_cnt == `BC_ZERO10 && q.bank[b].ras_cnt == 8'h00) begin
                d.bank[b].open = 1'b0;
                d.bank[b].ap_pend = 1'b0;
                d.bank[b].rp_cnt = q.cfg.trp;
                d.close[b] = 1'b1;
            end
            unique case (c.op)
                OP_NONE: begin
                end
                OP_ACT: begin
                    if (hit) begin
                        d.bank[b].open = 1'b1;
                        d.bank[b].ap_pend = 1'b0;
                        d.bank[b].ras_cnt = q.cfg.tras;
                    end
                end
                OP_RD: begin
                    // Flag low: plain burst, the bank stays open
                    if (hit && q.bank[b].open && all_flag && !q.bank[b].ap_pend) begin
                        d.bank[b].ap_pend = 1'b1;
                        d.bank[b].ap_cnt = rd_delay;
                    end
                end
                OP_WR, OP_MWR: begin
                    if (hit && q.bank[b].open && all_flag && !q.bank[b].ap_pend) begin
                        d.bank[b].ap_pend = 1'b1;
                        d.bank[b].ap_cnt = wr_delay;
                    end
                end
                OP_PRE: begin
                    // Idle banks are left alone; their recovery stays as it was
                    if ((all_flag || hit) && q.bank[b].open) begin
                        d.bank[b].open = 1'b0;
                        d.bank[b].ap_pend = 1'b0;
                        d.bank[b].rp_cnt = all_flag ? q.cfg.trpab : q.cfg.trp;
                        d.close[b] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data is latched in the setup phase so pready can stay high
        if (psel && !penable) begin
            d.prdata = 32'h0000_0000;
            if (paddr == `BC_CFG_OFF) begin
                d.prdata[`BC_CFG_NRTP] = q.cfg.nrtp;
                d.prdata[`BC_CFG_NWR] = q.cfg.nwr;
                d.prdata[`BC_CFG_WL] = q.cfg.wl;
                d.prdata[`BC_CFG_BL32] = q.cfg.bl32;
            end else if (paddr == `BC_TIM_OFF) begin
                d.prdata[`BC_TIM_TRAS] = q.cfg.tras;
                d.prdata[`BC_TIM_TRP] = q.cfg.trp;
                d.prdata[`BC_TIM_TRPAB] = q.cfg.trpab;
            end else if (paddr == `BC_STAT_OFF) begin
                d.prdata[`BC_STAT_OPEN] = bank_open;
                d.prdata[`BC_STAT_BUSY] = busy;
                d.prdata[`BC_STAT_APPEND] = ap_pend;
            end
        end
        if (wr_acc && paddr == `BC_CFG_OFF) begin
            d.cfg.nrtp = pwdata[`BC_CFG_NRTP];
            d.cfg.nwr = pwdata[`BC_CFG_NWR];
            d.cfg.wl = pwdata[`BC_CFG_WL];
            d.cfg.bl32 = pwdata[`BC_CFG_BL32];
        end
        if (wr_acc && paddr == `BC_TIM_OFF) begin
            d.cfg.tras = pwdata[`BC_TIM_TRAS];
            d.cfg.trp = pwdata[`BC_TIM_TRP];
            d.cfg.trpab = pwdata[`BC_TIM_TRPAB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.cfg.nrtp <= `BC_RST_NRTP;
            q.cfg.nwr <= `BC_RST_NWR;
            q.cfg.wl <= `BC_RST_WL;
            q.cfg.tras <= `BC_RST_TRAS;
            q.cfg.trp <= `BC_RST_TRP;
            q.cfg.trpab <= `BC_RST_TRPAB;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pre_all;
        (q.sync2.op == OP_PRE && q.sync2.ca1[5]) |=> (bank_open == 8'h00);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("all-bank close left a bank open");

    property p_pre_single;
        (q.sync2.op == OP_PRE && !q.sync2.ca1[5] && q.bank[0].open && q.sync2.ca2[2:0] != 3'h0)
            |=> bank_open[0] || bank_close_start[0];
    endproperty
    a_pre_single: assert property (p_pre_single) else $error("single close hit the wrong bank");

    property p_pre_sel;
        (q.sync2.op == OP_PRE && !q.sync2.ca1[5] && q.sync2.ca2[2:0] == 3'h3 && bank_open[3] && !ap_pend[3])
            |=> !bank_open[3] && bank_close_start[3] && q.bank[3].rp_cnt == $past(q.cfg.trp);
    endproperty
    a_pre_sel: assert property (p_pre_sel) else $error("selected bank did not close");

    property p_pre_ab_trp;
        (q.sync2.op == OP_PRE && q.sync2.ca1[5] && bank_open[5]) |=> q.bank[5].rp_cnt == $past(q.cfg.trpab);
    endproperty
    a_pre_ab_trp: assert property (p_pre_ab_trp) else $error("all-bank recovery not loaded");

    property p_idle_close;
        (q.sync2.op == OP_PRE && !bank_open[1] && !busy[1]) |=> !busy[1] && !bank_close_start[1];
    endproperty
    a_idle_close: assert property (p_idle_close) else $error("closing an idle bank had an effect");

    property p_no_flag;
        (q.sync2.op == OP_RD && !q.sync2.ca1[5] && q.sync2.ca2[2:0] == 3'h2 && bank_open[2] && !ap_pend[2])
            |=> bank_open[2] && !ap_pend[2];
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("plain read scheduled a close");

    property p_rd_ap;
        (q.sync2.op == OP_RD && q.sync2.ca1[5] && q.sync2.ca2[2:0] == 3'h0 && bank_open[0] && !ap_pend[0])
            |=> ap_pend[0] && q.bank[0].ap_cnt == ({2'b00, $past(q.cfg.nrtp)} + ($past(q.cfg.bl32) ? 10'h008 : 10'h000));
    endproperty
    a_rd_ap: assert property (p_rd_ap) else $error("read auto close delay wrong");

    property p_wr_ap;
        (q.sync2.op == OP_WR && q.sync2.ca1[5] && q.sync2.ca2[2:0] == 3'h0 && bank_open[0] && !ap_pend[0])
            |=> q.bank[0].ap_cnt == ({2'b00, $past(q.cfg.wl)} + ($past(q.cfg.bl32) ? 10'h010 : 10'h008)
                + 10'h001 + {2'b00, $past(q.cfg.nwr)});
    endproperty
    a_wr_ap: assert property (p_wr_ap) else $error("write auto close delay wrong");

    property p_ras_lock;
        bank_close_start[4] && !$past(q.sync2.op == OP_PRE) |-> $past(q.bank[4].ras_cnt) == 8'h00;
    endproperty
    a_ras_lock: assert property (p_ras_lock) else $error("auto close broke tRAS");

    property p_ap_fire;
        (ap_pend[6] && q.bank[6].ap_cnt == 10'h000 && q.bank[6].ras_cnt == 8'h00)
            |=> bank_close_start[6] && !bank_open[6] && q.bank[6].rp_cnt == $past(q.cfg.trp);
    endproperty
    a_ap_fire: assert property (p_ap_fire) else $error("auto close did not start on time");

    property p_unmapped;
        (psel && penable && paddr == 8'h0c) |-> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

endmodule // bank_precharge_timing
`default_nettype wire

// ### verification/host_ctrl_model.sv
// Purpose: Memory controller model driving the command pins of the bank close block
// Assumes: Callers space commands by the recovery, row-cycle and burst-to-close gaps
// Notes: Idle cycles invert the CA lines so a stale value is never mistaken for a command
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
    // Clock
    input wire logic pclk,
    // Command pins
    output var bank_close_pkg::cmd_in_t cmd_in
);
    import bank_close_pkg::*;

    initial cmd_in = '0;

    // One command cycle, then released
    task automatic issue(input cmd_op_t op, input logic [5:0] ca1, input logic [5:0] ca2);
        @(posedge pclk);
        cmd_in <= '{op, ca1, ca2};
        @(posedge pclk);
        cmd_in <= '{OP_NONE, ~ca1, ~ca2};
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// ### verification/bank_precharge_timing_bench.sv
// Purpose: Self-checking bench of the bank close block
// Assumes: Zero-wait APB slave; commands act three edges after they are driven
// Notes: Register reads first, then table rows, then codes, lockout and reset by hand
`timescale 1ns/1ns
`default_nettype none
`include "bank_close_regs.svh"
module bank_precharge_timing_bench;
    import bank_close_pkg::*;

    typedef struct packed {
        logic [31:0] cfg;
        logic [7:0] open;
        cmd_op_t op;
        logic [5:0] ca1;
        logic [5:0] ca2;
        logic [7:0] mask;
        logic [7:0] n;
    } row_t;

    // Delay counted in edges after the command is released
    localparam row_t ROWS [0:10] = '{
        '{32'h00040808, 8'h08, OP_PRE, 6'h00, 6'h03, 8'h08, 8'h02},
        '{32'h00040808, 8'hff, OP_PRE, 6'h00, 6'h06, 8'h40, 8'h02},
        '{32'h00040808, 8'h21, OP_PRE, 6'h20, 6'h05, 8'h21, 8'h02},
        '{32'h00040808, 8'h00, OP_PRE, 6'h00, 6'h04, 8'h00, 8'h00},
        '{32'h00040808, 8'h04, OP_RD, 6'h20, 6'h02, 8'h04, 8'h0b},
        '{32'h01040808, 8'h01, OP_RD, 6'h20, 6'h00, 8'h01, 8'h13},
        '{32'h00040808, 8'h01, OP_WR, 6'h20, 6'h00, 8'h01, 8'h18},
        '{32'h01040808, 8'h10, OP_WR, 6'h20, 6'h04, 8'h10, 8'h20},
        '{32'h00040808, 8'h80, OP_MWR, 6'h20, 6'h07, 8'h80, 8'h18},
        '{32'h00040808, 8'h04, OP_RD, 6'h00, 6'h02, 8'h00, 8'h00},
        '{32'h00040808, 8'h02, OP_MWR, 6'h00, 6'h01, 8'h00, 8'h00}
    };

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cmd_in_t cmd_in;
    logic [7:0] bank_open;
    logic [7:0] bank_close_start;
    logic [31:0] rd;
    logic err;
    logic [7:0] m;
    int n;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    always #20 pclk = ~pclk;

    bank_precharge_timing i_bank_precharge_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_in(cmd_in), .bank_open(bank_open), .bank_close_start(bank_close_start));
    host_ctrl_model i_host_ctrl_model (.pclk(pclk), .cmd_in(cmd_in));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // No wait limit here: only the cycle ceiling ends a stuck transfer
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for the first close pulse; n stays 0 when none comes
    task automatic wait_close(input int limit);
        m = 8'h00;
        for (n = 1; n <= limit; n++) begin
            @(posedge pclk);
            #1;
            if (bank_close_start !== 8'h00) break;
        end
        if (n > limit) n = 0;
        else m = bank_close_start;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `BC_CFG_OFF, 32'h0);
        check("cfg reset", 32'h00040808, rd);
        apb(1'b0, `BC_TIM_OFF, 32'h0);
        check("tim reset", 32'h00151228, rd);
        apb(1'b1, `BC_STAT_OFF, 32'hffffffff);
        apb(1'b0, `BC_STAT_OFF, 32'h0);
        check("stat read only", 32'h0, rd);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        // Short tRAS so the table measures only the close delays
        apb(1'b1, `BC_TIM_OFF, 32'h00151201);
        foreach (ROWS[i]) begin
            apb(1'b1, `BC_CFG_OFF, ROWS[i].cfg);
            for (int b = 0; b < 8; b++) begin
                if (ROWS[i].open[b]) i_host_ctrl_model.issue(OP_ACT, 6'h00, 6'(b));
            end
            repeat (4) @(posedge pclk);
            i_host_ctrl_model.issue(ROWS[i].op, ROWS[i].ca1, ROWS[i].ca2);
            wait_close(60);
            check("close banks", {24'h0, ROWS[i].mask}, {24'h0, m});
            check("close delay", {24'h0, ROWS[i].n}, n);
            check("open banks", {24'h0, ROWS[i].open & ~ROWS[i].mask}, {24'h0, bank_open});
            i_host_ctrl_model.issue(OP_PRE, 6'h20, 6'h00);
            repeat (30) @(posedge pclk);
        end
        apb(1'b1, `BC_CFG_OFF, 32'h00040808);
        for (int b = 0; b < 8; b++) begin
            i_host_ctrl_model.issue(OP_ACT, 6'h00, 6'(b));
            i_host_ctrl_model.issue(OP_PRE, 6'h00, 6'(b));
            wait_close(10);
            check("bank code", 32'h1 << b, {24'h0, m});
            repeat (20) @(posedge pclk);
        end
        // Auto close right after activate must wait out tRAS
        apb(1'b1, `BC_TIM_OFF, 32'h00151228);
        i_host_ctrl_model.issue(OP_ACT, 6'h00, 6'h06);
        i_host_ctrl_model.issue(OP_RD, 6'h20, 6'h06);
        wait_close(80);
        check("ras lockout", 32'h1, {31'h0, n >= 38 && n <= 46});
        repeat (30) @(posedge pclk);
        // Move both registers off their reset values so the reset is seen
        apb(1'b1, `BC_TIM_OFF, 32'h00151201);
        apb(1'b1, `BC_CFG_OFF, 32'h01040808);
        i_host_ctrl_model.issue(OP_ACT, 6'h00, 6'h00);
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("open after reset", 32'h0, {24'h0, bank_open});
        apb(1'b0, `BC_TIM_OFF, 32'h0);
        check("tim after reset", 32'h00151228, rd);
        apb(1'b0, `BC_CFG_OFF, 32'h0);
        check("cfg after reset", 32'h00040808, rd);
        finish_test();
    end
endmodule // bank_precharge_timing_bench
`default_nettype wire
